// ==== hdl/mlme_defines.vh ====
// Purpose : constants for the move/logic/multiply execute block
// Assumes : 16-bit and 32-bit instruction words presented by fetch
// Notes   : definitions only
`ifndef MLME_DEFINES_VH
`define MLME_DEFINES_VH
// ************************************************************
// opcode match values
// ************************************************************
`define MLME_MOVI_OP      5'h04        // bits 15:11 of move immediate
`define MLME_MOVR_OP      8'h46        // bits 15:8 of move register
`define MLME_MOVRS_OP     10'h000      // bits 15:6 flag-setting register move
`define MLME_MUL_OP       10'h10D      // bits 15:6 multiply
`define MLME_MVN_OP       10'h10F      // bits 15:6 bitwise not
`define MLME_ORR_OP       10'h10C      // bits 15:6 bitwise or
`define MLME_NOP_OP       16'hBF00     // whole no-operation word
`define MLME_MRS_HI       16'hF3EF     // first halfword of special read
`define MLME_MRS_LO_MASK  16'hD000     // fixed bits of second halfword
`define MLME_MRS_LO_VAL   16'h8000
`define MLME_MSR_HI_MASK  16'hFFF0
`define MLME_MSR_HI_VAL   16'hF380
`define MLME_MSR_LO_MASK  16'hDF00
`define MLME_MSR_LO_VAL   16'h8800
// ************************************************************
// special register selects
// ************************************************************
`define MLME_SPEC_APP_STATUS_FLAGS    8'h00
`define MLME_SPEC_CTRL    8'h14
`define MLME_PC_INDEX     4'hF
`endif

// ==== hdl/mlme_flag_unit.v ====
// Purpose : next condition flag values for a data operation
// Assumes : carry-in is already the shifter carry of the operation
// Notes   : overflow always passes through
`timescale 1ns/1ps
module mlme_flag_unit (
    input  wire [31:0] result_i,     // operation result
    input  wire        carry_i,      // operation carry out
    input  wire        set_i,        // flags are to change
    input  wire [3:0]  flags_i,      // current n z c v
    output wire [3:0]  flags_o       // next n z c v
);
    // overflow never touched by this subset
    wire [3:0] upd = {result_i[31], (result_i == 32'h0000_0000), carry_i, flags_i[0]};
    assign flags_o = set_i ? upd : flags_i;
endmodule

// ==== hdl/mlme_exec.v ====
// Purpose : decode and execute a move/logic/multiply instruction subset
// Assumes : register file read is combinational via ra/rb index ports
// Notes   : one instruction per valid strobe, results registered one cycle later
`timescale 1ns/1ps
`include "mlme_defines.vh"
// How it works
// - immediate zero-extended to 32 bits, carry kept
// - flags: n=bit31, z=zero, c=carry, v kept
// - flag-setting forms update only outside conditional block, except register move, which sets flags inside it too
// - register move: high bit prefixes destination, no flags
// - register move to pc branches there
// - special read copies special to general register
// - special write copies general to special register
// - multiply keeps low 32 product bits, sets flags
// - bitwise not inverts source register
// - second operand shifted left zero, carry kept
// - or of first operand and second operand
// - two-operand or: one field destination and first
// - no-operation changes nothing
// - no-operation timing is not guaranteed
module mlme_exec (
    input  wire        clock_i,            // core clock
    input  wire        rst_i,              // async reset, active high
    input  wire        instr_valid_i,      // instruction present
    input  wire [15:0] instr_hi_i,         // first halfword
    input  wire [15:0] instr_lo_i,         // second halfword of 32-bit forms
    input  wire        in_cond_block_i,    // inside conditional block
    input  wire        privileged_i,       // current mode privileged
    output wire [3:0]  ra_idx_o,           // read port a index
    input  wire [31:0] ra_data_i,          // read port a data
    output wire [3:0]  rb_idx_o,           // read port b index
    input  wire [31:0] rb_data_i,          // read port b data
    input  wire [31:0] spec_rdata_i,       // special register read data
    output wire [7:0]  spec_sel_o,         // special register select
    output reg         wr_en_o,            // register write strobe
    output reg  [3:0]  wr_idx_o,           // register write index
    output reg  [31:0] wr_data_o,          // register write data
    output reg         branch_o,           // branch strobe
    output reg  [31:0] branch_addr_o,      // branch target
    output reg         spec_wr_o,          // special register write strobe
    output reg  [7:0]  spec_wsel_o,        // special register write select
    output reg  [31:0] spec_wdata_o,       // special register write data
    output reg         sys_instr_o,        // last instruction was system class
    output reg         priv_fault_o,       // system instruction while unprivileged
    output reg         undef_o,            // not decoded by this block
    output wire        negative_flag_o,    // n flag
    output wire        zero_flag_o,        // z flag
    output wire        carry_flag_o,       // c flag
    output wire        overflow_flag_o     // v flag
);
    // ************************************************************
    // decode
    // ************************************************************
    localparam [3:0] OP_NONE = 4'h0;
    localparam [3:0] OP_MOVI = 4'h1;
    localparam [3:0] OP_MOVR = 4'h2;
    localparam [3:0] OP_MOVE_SET_FLAGS = 4'h3;
    localparam [3:0] OP_MRS  = 4'h4;
    localparam [3:0] OP_MSR  = 4'h5;
    localparam [3:0] OP_MUL  = 4'h6;
    localparam [3:0] OP_MVN  = 4'h7;
    localparam [3:0] OP_ORR  = 4'h8;
    localparam [3:0] OP_NOP  = 4'h9;

    // ************************************************************
    // helpers
    // ************************************************************
    // low registers only: a three-bit field names r0..r7
    function [3:0] lo_index;
        input [2:0] fld;
        lo_index = {1'b0, fld};
    endfunction

    // fixed bits of a 32-bit form, ignoring its register and select fields
    function masked_eq;
        input [15:0] word;
        input [15:0] mask;
        input [15:0] match;
        masked_eq = (word & mask) == match;
    endfunction

    // app status and control stay open to unprivileged code on reads
    function is_sys_read;
        input [7:0] sel;
        is_sys_read = (sel != `MLME_SPEC_APP_STATUS_FLAGS) && (sel != `MLME_SPEC_CTRL);
    endfunction

    // only app status stays open to unprivileged code on writes
    function is_sys_write;
        input [7:0] sel;
        is_sys_write = (sel != `MLME_SPEC_APP_STATUS_FLAGS);
    endfunction

    reg  [3:0] flags_q;                    // n z c v
    reg  [3:0] op;
    wire [3:0] lo_rd  = lo_index(instr_hi_i[2:0]);
    wire [3:0] fld_a  = lo_index(instr_hi_i[2:0]);
    wire [3:0] fld_b  = lo_index(instr_hi_i[5:3]);

    // the encodings do not overlap, so the order of the tests is only for reading
    always @* begin
        op = OP_NONE;
        if (instr_hi_i[15:11] == `MLME_MOVI_OP)
            op = OP_MOVI;
        else if (instr_hi_i[15:8] == `MLME_MOVR_OP)
            op = OP_MOVR;
        else if (instr_hi_i[15:6] == `MLME_MOVRS_OP)
            op = OP_MOVE_SET_FLAGS;
        else if (instr_hi_i[15:6] == `MLME_MUL_OP)
            op = OP_MUL;
        else if (instr_hi_i[15:6] == `MLME_MVN_OP)
            op = OP_MVN;
        else if (instr_hi_i[15:6] == `MLME_ORR_OP)
            op = OP_ORR;
        else if (instr_hi_i == `MLME_NOP_OP)
            op = OP_NOP;
        else if (instr_hi_i == `MLME_MRS_HI &&
                 masked_eq(instr_lo_i, `MLME_MRS_LO_MASK, `MLME_MRS_LO_VAL))
            op = OP_MRS;
        else if (masked_eq(instr_hi_i, `MLME_MSR_HI_MASK, `MLME_MSR_HI_VAL) &&
                 masked_eq(instr_lo_i, `MLME_MSR_LO_MASK, `MLME_MSR_LO_VAL))
            op = OP_MSR;
    end

    // ************************************************************
    // operand selection
    // ************************************************************
    // indices are pure decode, so the register file answers in the same cycle
    reg [3:0] ra_idx;
    reg [3:0] rb_idx;
    always @* begin
        ra_idx = fld_b;
        rb_idx = fld_a;
        case (op)
            OP_MOVR: ra_idx = instr_hi_i[6:3];              // full 4-bit source
            OP_MSR:  ra_idx = instr_hi_i[3:0];
            OP_MUL:  begin
                ra_idx = fld_b;                             // first operand
                rb_idx = fld_a;                             // shared dest/second
            end
            OP_ORR:  begin
                ra_idx = fld_a;                             // dest is also first
                rb_idx = fld_b;                             // separate second field
            end
            default: begin
                ra_idx = fld_b;
                rb_idx = fld_a;
            end
        endcase
    end
    assign ra_idx_o   = ra_idx;
    assign rb_idx_o   = rb_idx;
    assign spec_sel_o = instr_lo_i[7:0];

    // ************************************************************
    // shifter and multiplier
    // ************************************************************
    // left shift by zero: value unchanged, carry is the old carry flag
    wire [31:0] shifted   = (op == OP_ORR) ? rb_data_i : ra_data_i;
    wire        shift_c   = flags_q[1];
    // only the low word is kept; it is the same for signed and unsigned operands
    wire [63:0] product   = ra_data_i * rb_data_i;

    // ************************************************************
    // execute
    // ************************************************************
    reg  [31:0] result;
    reg  [3:0]  dest;
    reg         do_wr;
    reg         set_fl;
    reg         carry_res;
    always @* begin
        result    = 32'h0000_0000;
        dest      = lo_rd;
        do_wr     = 1'b0;
        set_fl    = 1'b0;
        carry_res = flags_q[1];
        case (op)
            OP_MOVI: begin
                result = {24'h00_0000, instr_hi_i[7:0]};
                dest   = lo_index(instr_hi_i[10:8]);
                do_wr  = 1'b1;
                set_fl = ~in_cond_block_i;
                carry_res = flags_q[1];
            end
            OP_MOVR: begin
                result = ra_data_i;
                dest   = {instr_hi_i[7], instr_hi_i[2:0]};
                do_wr  = 1'b1;
                set_fl = 1'b0;
            end
            // flag-setting register move sets flags even inside a conditional block
            OP_MOVE_SET_FLAGS: begin
                result = ra_data_i;
                dest   = fld_a;
                do_wr  = 1'b1;
                set_fl = 1'b1;
            end
            OP_MRS: begin
                result = spec_rdata_i;
                dest   = instr_lo_i[11:8];
                do_wr  = 1'b1;
            end
            OP_MUL: begin
                result = product[31:0];
                dest   = fld_a;
                do_wr  = 1'b1;
                set_fl = ~in_cond_block_i;
            end
            OP_MVN: begin
                result    = ~shifted;
                dest      = fld_a;
                do_wr     = 1'b1;
                set_fl    = ~in_cond_block_i;
                carry_res = shift_c;
            end
            OP_ORR: begin
                result    = ra_data_i | shifted;
                dest      = fld_a;
                do_wr     = 1'b1;
                set_fl    = ~in_cond_block_i;
                carry_res = shift_c;
            end
            // no-op: no write, no flags, no branch; timing not promised
            OP_NOP:  do_wr = 1'b0;
            default: do_wr = 1'b0;
        endcase
    end

    // flags move only on a taken instruction
    wire [3:0] flags_d;
    mlme_flag_unit u_flags (
        .result_i (result),
        .carry_i  (carry_res),
        .set_i    (instr_valid_i & set_fl),
        .flags_i  (flags_q),
        .flags_o  (flags_d)
    );

    // ************************************************************
    // special register access and branch
    // ************************************************************
    wire is_sys_rd = is_sys_read(instr_lo_i[7:0]);
    wire is_sys_wr = is_sys_write(instr_lo_i[7:0]);
    wire sys_now   = (op == OP_MRS && is_sys_rd) || (op == OP_MSR && is_sys_wr);
    // a faulting access writes nothing, so the old state stays visible
    wire blocked   = sys_now & ~privileged_i;
    // pc belongs to fetch: a move to it becomes a branch, not a write
    wire to_pc     = do_wr && op == OP_MOVR && dest == `MLME_PC_INDEX;

    // ************************************************************
    // commit: register write and flags leave in the same cycle
    // ************************************************************
    // strobes last one cycle; data outputs hold until the next taken instruction
    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            flags_q       <= 4'h0;
            wr_en_o       <= 1'b0;
            wr_idx_o      <= 4'h0;
            wr_data_o     <= 32'h0000_0000;
            branch_o      <= 1'b0;
            branch_addr_o <= 32'h0000_0000;
            spec_wr_o     <= 1'b0;
            spec_wsel_o   <= 8'h00;
            spec_wdata_o  <= 32'h0000_0000;
            sys_instr_o   <= 1'b0;
            priv_fault_o  <= 1'b0;
            undef_o       <= 1'b0;
        end else begin
            wr_en_o      <= 1'b0;
            branch_o     <= 1'b0;
            spec_wr_o    <= 1'b0;
            sys_instr_o  <= 1'b0;
            priv_fault_o <= 1'b0;
            undef_o      <= 1'b0;
            if (instr_valid_i) begin
                flags_q      <= flags_d;
                wr_en_o      <= do_wr & ~to_pc & ~blocked;
                wr_idx_o     <= dest;
                wr_data_o    <= result;
                branch_o     <= to_pc;
                sys_instr_o  <= sys_now;
                priv_fault_o <= blocked;
                // anything outside this subset is left to the core's fault logic
                undef_o      <= (op == OP_NONE);
                if (to_pc)
                    branch_addr_o <= result;
                if (op == OP_MSR && !blocked) begin
                    spec_wr_o    <= 1'b1;
                    spec_wsel_o  <= instr_lo_i[7:0];
                    spec_wdata_o <= ra_data_i;
                end
            end
        end
    end

    // ************************************************************
    // flag outputs
    // ************************************************************
    assign negative_flag_o = flags_q[3];
    assign zero_flag_o     = flags_q[2];
    assign carry_flag_o    = flags_q[1];
    assign overflow_flag_o = flags_q[0];
endmodule

// ==== verif/mlme_exec_chk.sv ====
// Purpose : port assertions for the execute block
// Assumes : results show one cycle after the take edge
// Notes   : only decoded fields are tied to outputs, operand ports are not guessed
`timescale 1ns/1ps
module mlme_chk (
    input wire logic        clock_i,          // core clock
    input wire logic        rst_i,            // async reset, active high
    input wire logic        instr_valid_i,    // instruction taken this edge
    input wire logic        in_cond_block_i,  // inside conditional block
    input wire logic        privileged_i,     // privileged mode
    input wire logic [15:0] instr_hi_i,       // first halfword
    input wire logic [15:0] instr_lo_i,       // second halfword
    input wire logic        wr_en_o,          // register write strobe
    input wire logic        branch_o,         // branch strobe
    input wire logic        spec_wr_o,        // special write strobe
    input wire logic        priv_fault_o,     // privilege fault pulse
    input wire logic [3:0]  wr_idx_o,         // register write index
    input wire logic [31:0] wr_data_o,        // register write data
    input wire logic        negative_flag_o,  // n flag
    input wire logic        zero_flag_o,      // z flag
    input wire logic        carry_flag_o,     // c flag
    input wire logic        overflow_flag_o   // v flag
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    wire logic [3:0] flg = {negative_flag_o, zero_flag_o, carry_flag_o, overflow_flag_o};
    wire logic [15:0] hi = instr_hi_i;
    // ************************************************************
    // decode sequences
    // ************************************************************
    sequence s_movi; instr_valid_i && hi[15:11] == 5'h04; endsequence
    sequence s_alu; instr_valid_i && (hi[15:11] == 5'h04 || hi[15:6] == 10'h10F
        || hi[15:6] == 10'h10C || hi[15:6] == 10'h10D); endsequence
    sequence s_movr; instr_valid_i && hi[15:8] == 8'h46; endsequence
    sequence s_mrs_sys; instr_valid_i && !privileged_i && hi == 16'hF3EF
        && (instr_lo_i & 16'hD000) == 16'h8000
        && instr_lo_i[7:0] != 8'h00 && instr_lo_i[7:0] != 8'h14; endsequence
    property p_movi; s_movi |=> wr_en_o && wr_idx_o == {1'b0, $past(hi[10:8])}
        && wr_data_o == {24'h00_0000, $past(hi[7:0])}
        && carry_flag_o == $past(carry_flag_o); endproperty
    a_movi: assert property (p_movi) else $error("immediate move wrong");
    property p_nz; s_movi ##0 !in_cond_block_i |=> !negative_flag_o
        && zero_flag_o == ($past(hi[7:0]) == 8'h00); endproperty
    a_nz: assert property (p_nz) else $error("n or z wrong after move");
    property p_ovf; s_alu |=> $stable(overflow_flag_o); endproperty
    a_ovf: assert property (p_ovf) else $error("overflow flag moved");
    property p_cond; s_alu ##0 in_cond_block_i |=> $stable(flg); endproperty
    a_cond: assert property (p_cond) else $error("flags set inside block");
    property p_movr; s_movr ##0 !(hi[7] && hi[2:0] == 3'h7) |=> wr_en_o
        && wr_idx_o == {$past(hi[7]), $past(hi[2:0])} && $stable(flg); endproperty
    a_movr: assert property (p_movr) else $error("register move wrong");
    property p_topc; s_movr ##0 (hi[7] && hi[2:0] == 3'h7) |=> branch_o && !wr_en_o; endproperty
    a_topc: assert property (p_topc) else $error("move to pc did not branch");
    property p_mrs; s_mrs_sys |=> priv_fault_o && !wr_en_o; endproperty
    a_mrs: assert property (p_mrs) else $error("unprivileged special read");
    property p_msr; instr_valid_i && !privileged_i && hi[15:4] == 12'hF38
        && (instr_lo_i & 16'hDF00) == 16'h8800
        && instr_lo_i[7:0] != 8'h00 |=> priv_fault_o && !spec_wr_o; endproperty
    a_msr: assert property (p_msr) else $error("unprivileged special write");
    property p_nop; instr_valid_i && hi == 16'hBF00 |=> !wr_en_o && !branch_o
        && !spec_wr_o && $stable(flg); endproperty
    a_nop: assert property (p_nop) else $error("nop changed state");
    property p_commit; $changed(flg[3:2]) |-> wr_en_o || spec_wr_o; endproperty
    a_commit: assert property (p_commit) else $error("flags moved without write");
endmodule
bind mlme_exec mlme_chk chk_u (.clock_i(clock_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i),
    .in_cond_block_i(in_cond_block_i), .privileged_i(privileged_i), .instr_hi_i(instr_hi_i),
    .instr_lo_i(instr_lo_i), .wr_en_o(wr_en_o), .branch_o(branch_o), .spec_wr_o(spec_wr_o),
    .priv_fault_o(priv_fault_o), .wr_idx_o(wr_idx_o), .wr_data_o(wr_data_o),
    .negative_flag_o(negative_flag_o), .zero_flag_o(zero_flag_o),
    .carry_flag_o(carry_flag_o), .overflow_flag_o(overflow_flag_o));

// ==== verif/testbench.sv ====
// Purpose : directed bench for the execute block
// Assumes : register file modelled as a bench array read combinationally
// Notes   : special write to app status runs last, its flag effect is not modelled
`timescale 1ns/1ps
module testbench;
    logic        clock_i, rst_i, instr_valid_i, in_cond_block_i, privileged_i;
    logic [15:0] instr_hi_i, instr_lo_i;
    logic [31:0] spec_rdata_i;
    logic [31:0] regs [0:15];
    logic [3:0]  exp_flg;
    wire  [3:0]  ra_idx_o, rb_idx_o, wr_idx_o, flg;
    wire  [31:0] wr_data_o, branch_addr_o, spec_wdata_o;
    wire  [31:0] ra_data_i = regs[ra_idx_o];
    wire  [31:0] rb_data_i = regs[rb_idx_o];
    wire  [7:0]  spec_sel_o, spec_wsel_o;
    wire         wr_en_o, branch_o, spec_wr_o, sys_instr_o, priv_fault_o, undef_o;
    int          n_errors, n_checks, cyc;
    mlme_exec dut_u (.clock_i(clock_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i),
        .instr_hi_i(instr_hi_i), .instr_lo_i(instr_lo_i), .in_cond_block_i(in_cond_block_i),
        .privileged_i(privileged_i), .ra_idx_o(ra_idx_o), .ra_data_i(ra_data_i),
        .rb_idx_o(rb_idx_o), .rb_data_i(rb_data_i), .spec_rdata_i(spec_rdata_i),
        .spec_sel_o(spec_sel_o), .wr_en_o(wr_en_o), .wr_idx_o(wr_idx_o), .wr_data_o(wr_data_o),
        .branch_o(branch_o), .branch_addr_o(branch_addr_o), .spec_wr_o(spec_wr_o),
        .spec_wsel_o(spec_wsel_o), .spec_wdata_o(spec_wdata_o), .sys_instr_o(sys_instr_o),
        .priv_fault_o(priv_fault_o), .undef_o(undef_o), .negative_flag_o(flg[3]),
        .zero_flag_o(flg[2]), .carry_flag_o(flg[1]), .overflow_flag_o(flg[0]));
    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one instruction, then sample just after the edge where results land
    task automatic run(input logic [15:0] hi, lo, input logic cond, priv);
        @(posedge clock_i);
        instr_valid_i <= 1'b1;
        instr_hi_i <= hi;
        instr_lo_i <= lo;
        in_cond_block_i <= cond;
        privileged_i <= priv;
        @(posedge clock_i);
        instr_valid_i <= 1'b0;
        #1;
    endtask
    task automatic wr(input logic [3:0] idx, input logic [31:0] d, input logic setf);
        if (setf) exp_flg = {d[31], d == 32'h0000_0000, exp_flg[1:0]};
        chk("wr_en", wr_en_o, 1);
        chk("wr_idx", wr_idx_o, idx);
        chk("wr_data", wr_data_o, d);
        chk("flags", flg, exp_flg);
    endtask
    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_movi;
        run(16'h2380, 16'h0000, 0, 0);
        wr(4'h3, 32'h0000_0080, 1);
        run(16'h2500, 16'h0000, 0, 0);
        wr(4'h5, 32'h0000_0000, 1);
        run(16'h26FF, 16'h0000, 1, 0);
        wr(4'h6, 32'h0000_00FF, 0);
    endtask
    task automatic t_logic;
        run(16'h43D1, 16'h0000, 0, 0);
        wr(4'h1, ~regs[2], 1);
        run(16'h432C, 16'h0000, 0, 0);
        wr(4'h4, regs[4] | regs[5], 1);
        run(16'h4300, 16'h0000, 0, 0);
        wr(4'h0, 32'h0000_0000, 1);
        run(16'h432C, 16'h0000, 1, 0);
        wr(4'h4, regs[4] | regs[5], 0);
        run(16'h437E, 16'h0000, 0, 0);
        wr(4'h6, regs[6] * regs[7], 1);
        run(16'h437E, 16'h0000, 1, 0);
        wr(4'h6, regs[6] * regs[7], 0);
    endtask
    task automatic t_movr;
        run(16'h4699, 16'h0000, 0, 0);
        wr(4'h9, regs[3], 0);
        run(16'h0011, 16'h0000, 0, 0);
        wr(4'h1, regs[2], 1);
        run(16'h0000, 16'h0000, 1, 0);
        wr(4'h0, 32'h0000_0000, 1);
        run(16'h46D7, 16'h0000, 0, 0);
        chk("branch", branch_o, 1);
        chk("branch_addr", branch_addr_o, regs[10]);
        chk("no_write", wr_en_o, 0);
    endtask
    task automatic t_nop;
        run(16'hBF00, 16'h0000, 0, 0);
        chk("nop_state", {wr_en_o, branch_o, spec_wr_o, undef_o, flg}, exp_flg);
        run(16'hFFFF, 16'h0000, 0, 0);
        chk("undef", {undef_o, wr_en_o}, 2'b10);
    endtask
    task automatic t_spec;
        run(16'hF3EF, 16'h8208, 0, 1);
        chk("spec_sel", spec_sel_o, 8'h08);
        chk("sys", sys_instr_o, 1);
        wr(4'h2, spec_rdata_i, 0);
        run(16'hF3EF, 16'h8208, 0, 0);
        chk("read_fault", {priv_fault_o, wr_en_o}, 2'b10);
        run(16'hF3EF, 16'h8314, 0, 0);
        chk("ctrl_read", {priv_fault_o, sys_instr_o}, 2'b00);
        wr(4'h3, spec_rdata_i, 0);
        run(16'hF384, 16'h8810, 0, 0);
        chk("write_fault", {priv_fault_o, spec_wr_o}, 2'b10);
        run(16'hF384, 16'h8800, 0, 0);
        chk("spec_write", {spec_wr_o, sys_instr_o, spec_wsel_o}, 10'h200);
        chk("spec_wdata", spec_wdata_o, regs[4]);
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        clock_i = 0;
        forever #5 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 2000) begin
            n_errors++;
            wrap_up();
        end
    end
    initial begin
        {rst_i, instr_valid_i, in_cond_block_i, privileged_i} = 4'b1000;
        {instr_hi_i, instr_lo_i} = 32'h0000_0000;
        spec_rdata_i = 32'hCAFE_0123;
        exp_flg = 4'h0;
        for (int i = 0; i < 16; i++) regs[i] = 32'h1234_5679 * (i + 3);
        regs[0] = 32'h0000_0000;
        repeat (10) @(posedge clock_i);
        rst_i <= 1'b0;
        t_movi();
        t_logic();
        t_movr();
        t_nop();
        t_spec();
        wrap_up();
    end
endmodule
